// ===== rtl/array_counter_pkg.sv
// Purpose: constants and types for the array counter time base
// Assumes: 32-bit Avalon-MM register slave, one word per register
// Notes: byte registers sit in the low eight bits of a word
package array_counter_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
    // mode register fields
    localparam int MODE_IDLE_GATE = 7;
    localparam int MODE_WATCHDOG_ENABLE = 6;
    localparam int MODE_SRC_HI = 2;
    localparam int MODE_SRC_LO = 1;
    localparam int MODE_OVF_IRQ_ENABLE = 0;
    localparam logic [7:0] MODE_IMPL_MASK = 8'hc7;
    // control register fields
    localparam int CTRL_OVERFLOW_FLAG = 7;
    localparam int CTRL_RUN_BIT = 6;
    // interrupt status bits
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_MODULE = 1;
    localparam int IRQ_WIDTH = 2;
    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // machine cycle is twelve oscillator periods, fast source every four
    localparam int OSC_PER_MACHINE = 12;
    localparam int OSC_PER_FAST = 4;
    localparam logic [3:0] PRESCALE_LAST = 4'(OSC_PER_MACHINE - 1);

    typedef enum logic [1:0] {
        SRC_OSC12,
        SRC_OSC4,
        SRC_TIMER0,
        SRC_EXTERNAL
    } count_source_t;

    typedef struct packed {
        logic idle_gate;
        logic watchdog_enable;
        count_source_t source;
        logic overflow_irq_enable;
    } mode_t;
endpackage : array_counter_pkg

// ===== rtl/array_counter_timebase.sv
// Purpose: 16-bit time base counter of the counter array
// Assumes: i_osc_tick pulses once per oscillator period; inputs synchronous
// Notes: registers over Avalon-MM, one wait state on each access
// Notes on behaviour
// - free-running 16-bit counter in two bytes
// - count bytes readable and writable any time
// - osc/12 source: one step per machine cycle
// - osc/4 source: three steps per machine
// - timer 0 source: step per overflow
// - external source: step per falling edge
// - mode bits 2:1 select count source
// - mode bit 0 gates overflow interrupt on o_array_irq only
// - mode bit 7 stops counting in idle
// - mode bit 6 enables module 4 watchdog
// - overflow flag set on rollover
// - counts only while run bit set
// - mode bits 5:3 reserved, read zero
// - counter is common time base
// - overflow and module requests share interrupt
module array_counter_timebase (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_osc_tick,
    input wire logic i_timer0_overflow,
    input wire logic i_external_count_input,
    input wire logic i_idle_mode,
    input wire logic i_module_irq,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [15:0] o_time_base,
    output logic o_watchdog_enable,
    output logic o_array_irq,
    output logic o_irq
);
    array_counter_pkg::mode_t mode;
    logic run_bit;
    logic overflow_flag;
    logic [15:0] count;
    logic [3:0] prescale;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic [array_counter_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [array_counter_pkg::IRQ_WIDTH-1:0] irq_enable;
    logic access_done;
    logic [7:0] byte_addr;
    logic wr_go;
    logic rd_go;
    logic step;
    logic rollover;
    logic wr_low;
    logic wr_high;
    logic wr_mode;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_enable;
    logic [31:0] next_readdata;

    assign byte_addr = {1'b0, i_avs_address, 2'b00};
    // writes land on the edge where waitrequest is sampled low
    assign wr_go = i_avs_write && access_done;
    assign rd_go = i_avs_read && !access_done;
    assign wr_low = wr_go && i_avs_byteenable[0] && byte_addr == array_counter_pkg::ADDR_COUNT_LOW;
    assign wr_high = wr_go && i_avs_byteenable[0]
        && byte_addr == array_counter_pkg::ADDR_COUNT_HIGH;
    assign wr_mode = wr_go && i_avs_byteenable[0] && byte_addr == array_counter_pkg::ADDR_MODE;
    assign wr_ctrl = wr_go && i_avs_byteenable[0] && byte_addr == array_counter_pkg::ADDR_CONTROL;
    assign wr_clear = wr_go && i_avs_byteenable[0]
        && byte_addr == array_counter_pkg::ADDR_IRQ_CLEAR;
    assign wr_enable = wr_go && i_avs_byteenable[0]
        && byte_addr == array_counter_pkg::ADDR_IRQ_ENABLE;

    // wait state handshake
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            access_done <= 1'b0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            access_done <= (i_avs_read || i_avs_write) && !access_done;
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !access_done);
        end
    end

    // oscillator prescaler marks machine cycle boundaries
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prescale <= 4'h0;
        end else if (i_osc_tick) begin
            prescale <= (prescale == array_counter_pkg::PRESCALE_LAST) ? 4'h0 : prescale + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_sync1 <= 1'b1;
            ext_sync2 <= 1'b1;
            ext_prev <= 1'b1;
        end else begin
            ext_sync1 <= i_external_count_input;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
        end
    end

    always_comb begin
        step = 1'b0;
        case (mode.source)
            array_counter_pkg::SRC_OSC12: begin
                step = i_osc_tick && prescale == array_counter_pkg::PRESCALE_LAST;
            end
            array_counter_pkg::SRC_OSC4: begin
                step = i_osc_tick && prescale[1:0] == 2'(array_counter_pkg::OSC_PER_FAST - 1);
            end
            array_counter_pkg::SRC_TIMER0: begin
                step = i_timer0_overflow;
            end
            default: begin
                step = ext_prev && !ext_sync2;
            end
        endcase
        step = step && run_bit && !(mode.idle_gate && i_idle_mode);
    end
    assign rollover = step && count == 16'hffff;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count <= array_counter_pkg::COUNT_RESET;
        end else if (wr_low) begin
            count <= {count[15:8], i_avs_writedata[7:0]};
        end else if (wr_high) begin
            count <= {i_avs_writedata[7:0], count[7:0]};
        end else if (step) begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode <= array_counter_pkg::mode_t'(array_counter_pkg::MODE_RESET[4:0]);
        end else if (wr_mode) begin
            mode <= array_counter_pkg::mode_t'({i_avs_writedata[7:6], i_avs_writedata[2:0]});
        end
    end

    // overflow flag, set wins over software clear
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            run_bit <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                run_bit <= i_avs_writedata[array_counter_pkg::CTRL_RUN_BIT];
            end
            if (rollover) begin
                overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                overflow_flag <= i_avs_writedata[array_counter_pkg::CTRL_OVERFLOW_FLAG];
            end
        end
    end

    // sticky interrupt status, set wins over clear
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_status <= '0;
            irq_enable <= '0;
        end else begin
            for (int i = 0; i < array_counter_pkg::IRQ_WIDTH; i++) begin
                if ((i == array_counter_pkg::IRQ_OVERFLOW && rollover)
                    || (i == array_counter_pkg::IRQ_MODULE && i_module_irq)) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_clear && i_avs_writedata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
            if (wr_enable) begin
                irq_enable <= i_avs_writedata[array_counter_pkg::IRQ_WIDTH-1:0];
            end
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        if (byte_addr == array_counter_pkg::ADDR_COUNT_LOW) begin
            next_readdata[7:0] = count[7:0];
        end else if (byte_addr == array_counter_pkg::ADDR_COUNT_HIGH) begin
            next_readdata[7:0] = count[15:8];
        end else if (byte_addr == array_counter_pkg::ADDR_MODE) begin
            next_readdata[7:0] = {mode[4:3], 3'b000, mode[2:0]};
        end else if (byte_addr == array_counter_pkg::ADDR_CONTROL) begin
            next_readdata[array_counter_pkg::CTRL_OVERFLOW_FLAG] = overflow_flag;
            next_readdata[array_counter_pkg::CTRL_RUN_BIT] = run_bit;
        end else if (byte_addr == array_counter_pkg::ADDR_IRQ_STATUS) begin
            next_readdata[array_counter_pkg::IRQ_WIDTH-1:0] = irq_status;
        end else if (byte_addr == array_counter_pkg::ADDR_IRQ_ENABLE) begin
            next_readdata[array_counter_pkg::IRQ_WIDTH-1:0] = irq_enable;
        end
    end

    // registered outputs
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_avs_readdata <= 32'h0000_0000;
            o_time_base <= array_counter_pkg::COUNT_RESET;
            o_watchdog_enable <= 1'b0;
            o_array_irq <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            if (rd_go) begin
                o_avs_readdata <= next_readdata;
            end
            o_time_base <= count;
            o_watchdog_enable <= mode.watchdog_enable;
            o_array_irq <= (overflow_flag && mode.overflow_irq_enable) || i_module_irq;
            o_irq <= |(irq_status & irq_enable);
        end
    end
endmodule : array_counter_timebase

// ===== testbench/array_counter_timebase_props.sv
// Purpose: port-level checks for the array counter time base
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound from the bench top
module array_counter_timebase_props (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic i_module_irq,
    input wire logic o_avs_waitrequest,
    input wire logic [15:0] o_time_base,
    input wire logic o_watchdog_enable,
    input wire logic o_array_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);
    sequence s_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_ack;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    a_req_answer: assert property (s_req |=> s_ack)
        else $error("request not answered in one cycle");
    a_wait_idle: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("waitrequest low without request");
    a_wait_cause: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
        else $error("answer without cause");
    a_count_step: assert property ($changed(o_time_base) |->
        o_time_base == $past(o_time_base) + 16'h0001 || $past(i_avs_write)
        || $past(i_avs_write, 2))
        else $error("time base jumped");
    a_wdog_change: assert property ($changed(o_watchdog_enable) |->
        $past(i_avs_write) || $past(i_avs_write, 2))
        else $error("watchdog enable changed alone");
    a_module_irq: assert property (i_module_irq |=> o_array_irq)
        else $error("module request not on array irq");
    a_irq_cause: assert property ($rose(o_array_irq) |-> $past(i_module_irq)
        || o_time_base < 16'h0004 || $past(i_avs_write) || $past(i_avs_write, 2))
        else $error("array irq without cause");
    a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
endmodule : array_counter_timebase_props

// ===== testbench/cpu_reg_master.sv
// Purpose: cpu-side register master for the counter bench
// Assumes: avalon-mm slave with waitrequest
// Notes: gives up after a bounded wait and reports it
module cpu_reg_master (
    input wire logic i_ref_clk,
    input wire logic i_waitrequest,
    input wire logic [31:0] i_readdata,
    output logic [4:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_address = 5'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h00000000;
        o_byteenable = 4'h1;
    end
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d,
                          output logic [31:0] q, output logic ok);
        ok = 1'b0;
        q = 32'h00000000;
        @(posedge i_ref_clk);
        o_address <= a[6:2];
        o_read <= !w;
        o_write <= w;
        o_writedata <= {24'h000000, d};
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge i_ref_clk);
            if (!i_waitrequest) begin
                ok = 1'b1;
                q = i_readdata;
            end
        end
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_writedata <= ~o_writedata;
    endtask : access
endmodule : cpu_reg_master

// ===== testbench/array_counter_timebase_tb_top.sv
// Purpose: self-checking bench for the array counter time base
// Assumes: oscillator tick tied high, machine cycle of twelve clocks
// Notes: count rates measured on the time base output
module array_counter_timebase_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic t0 = 1'b0;
    logic ext = 1'b1;
    logic idle = 1'b0;
    logic mirq = 1'b0;
    logic [4:0] adr;
    logic rd, wr, wreq, wdog, airq, irq;
    logic [31:0] wdat, rdat, q;
    logic [3:0] be;
    logic [15:0] tb, t_start;
    int err_count = 0;
    int comparisons = 0;
    logic [7:0] modes [6] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h80, 8'h00};
    logic [5:0] idles = 6'b110000;
    logic [15:0] steps [6] = '{16'd10, 16'd30, 16'd10, 16'd10, 16'd0, 16'd10};
    always #2.5 i_ref_clk = ~i_ref_clk;
    array_counter_timebase i_dut (.i_ref_clk, .i_rstn, .i_osc_tick(1'b1),
        .i_timer0_overflow(t0), .i_external_count_input(ext), .i_idle_mode(idle),
        .i_module_irq(mirq), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .o_time_base(tb), .o_watchdog_enable(wdog),
        .o_array_irq(airq), .o_irq(irq));
    cpu_reg_master i_cpu (.i_ref_clk, .i_waitrequest(wreq), .i_readdata(rdat),
        .o_address(adr), .o_read(rd), .o_write(wr), .o_writedata(wdat), .o_byteenable(be));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
        logic ok;
        i_cpu.access(a, w, d, q, ok);
        if (!ok) begin
            err_count++;
            conclude();
        end
    endtask : acc
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        acc(array_counter_pkg::ADDR_MODE, 0, 0);
        chk(q, 32'h0, "mode reset");
        acc(array_counter_pkg::ADDR_MODE, 1, 8'hff);
        acc(array_counter_pkg::ADDR_MODE, 0, 0);
        chk(q, 32'h000000c7, "mode reserved");
        chk(wdog, 1'b1, "watchdog enable");
        acc(array_counter_pkg::ADDR_CONTROL, 1, 8'h40);
        for (int k = 0; k < 6; k++) begin
            acc(array_counter_pkg::ADDR_MODE, 1, modes[k]);
            idle <= idles[k];
            @(posedge i_ref_clk);
            t_start = tb;
            for (int i = 0; i < 120; i++) begin
                @(posedge i_ref_clk);
                t0 <= (k == 2) && (i % 12 == 0);
                if (k == 3) ext <= ((i / 6) % 2) == 1;
            end
            chk(tb - t_start, steps[k], "count steps");
            idle <= 1'b0;
        end
        chk(wdog, 1'b0, "watchdog enable");
        acc(array_counter_pkg::ADDR_COUNT_HIGH, 1, 8'h5a);
        acc(array_counter_pkg::ADDR_COUNT_HIGH, 0, 0);
        chk(q, 32'h5a, "high byte");
        acc(array_counter_pkg::ADDR_CONTROL, 1, 8'h00);
        repeat (3) @(posedge i_ref_clk);
        t_start = tb;
        repeat (24) @(posedge i_ref_clk);
        chk(tb, t_start, "stopped count");
        acc(array_counter_pkg::ADDR_MODE, 1, 8'h03);
        acc(array_counter_pkg::ADDR_COUNT_HIGH, 1, 8'hff);
        acc(array_counter_pkg::ADDR_COUNT_LOW, 1, 8'hf0);
        acc(array_counter_pkg::ADDR_CONTROL, 1, 8'h40);
        repeat (80) @(posedge i_ref_clk);
        acc(array_counter_pkg::ADDR_CONTROL, 0, 0);
        chk(q[7], 1'b1, "overflow flag");
        chk(airq, 1'b1, "array irq");
        acc(array_counter_pkg::ADDR_IRQ_STATUS, 0, 0);
        chk(q, 32'h1, "irq status");
        chk(irq, 1'b0, "masked irq");
        acc(array_counter_pkg::ADDR_IRQ_ENABLE, 1, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        chk(irq, 1'b1, "enabled irq");
        acc(array_counter_pkg::ADDR_IRQ_CLEAR, 1, 8'h01);
        acc(array_counter_pkg::ADDR_CONTROL, 1, 8'h40);
        repeat (2) @(posedge i_ref_clk);
        chk({irq, airq}, 2'b00, "cleared irq");
        mirq <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        chk(airq, 1'b1, "module irq");
        mirq <= 1'b0;
        acc(array_counter_pkg::ADDR_IRQ_STATUS, 0, 0);
        chk(q, 32'h2, "module status");
        acc(8'h1c, 0, 0);
        chk(q, 32'h0, "unmapped");
        conclude();
    end
endmodule : array_counter_timebase_tb_top
bind array_counter_timebase array_counter_timebase_props i_props (.i_ref_clk, .i_rstn,
    .i_avs_read, .i_avs_write, .i_module_irq, .o_avs_waitrequest, .o_time_base,
    .o_watchdog_enable, .o_array_irq);
